// ==== ccbq_pkg.sv ====
package ccbq_pkg;
   localparam int CTRL_NO_DISC = 3;
   localparam int CTRL_NO_UNDERRUN = 4;
   localparam int CTRL_NO_DATA = 5;
   localparam int CTRL_NO_ZERO_STAT = 6;
   localparam int CTRL_NO_INTR = 7;
   localparam logic [7:0] CTRL_USED_MASK = 8'hf8;
   localparam int LUN_TAG_EN = 5;
   localparam int LUN_TYPE_LO = 6;
   localparam logic [7:0] IDENT_NO_DISC = 8'h80;
   localparam logic [7:0] IDENT_DISC = 8'hc0;
   localparam logic [7:0] MSG_TAG_SIMPLE = 8'h20;
   localparam logic [7:0] MSG_TAG_HEAD = 8'h21;
   localparam logic [7:0] MSG_TAG_ORDERED = 8'h22;
   localparam logic [7:0] STAT_OK = 8'h00;
   localparam logic [7:0] STAT_UNDERRUN = 8'h12;
   localparam logic [7:0] STAT_RST_SELF = 8'h22;
   localparam logic [7:0] STAT_RST_OTHER = 8'h23;
   localparam logic [7:0] STAT_UNTAGGED_RECON = 8'h24;
   localparam logic [7:0] STAT_BDR = 8'h25;
   localparam logic [7:0] OPC_RESID_A = 8'h03;
   localparam logic [7:0] OPC_RESID_B = 8'h04;
   localparam logic [31:0] SG_ENTRY_BYTES = 32'h0000_0008;
   localparam int SG_CNT_W = 14;
   localparam logic [13:0] SG_MAX_ENTRIES = 14'h2000;
   localparam int NSLOT = 8;
   localparam int SLOT_W = 3;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 32;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SELECT = 3'b001,
      ST_SG_REQ = 3'b010,
      ST_SG_WAIT = 3'b011,
      ST_DATA = 3'b100,
      ST_DONE = 3'b101
   } ccbq_state_t;
endpackage : ccbq_pkg

// ==== ccbq_fifo.sv ====
`timescale 1ns/1ps
module ccbq_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ccbq_fifo

// ==== ccbq_ctrl.sv ====
`timescale 1ns/1ps
module ccbq_ctrl (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic target_mode,
   input wire logic opt_valid,
   input wire logic [7:0] opt_no_disc,
   input wire logic auto_sense_en,
   input wire logic [7:0] sync_needed,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_opcode,
   input wire logic [7:0] cmd_control,
   input wire logic [7:0] cmd_lun_tag,
   input wire logic [2:0] cmd_target,
   input wire logic cmd_sg,
   input wire logic [31:0] cmd_data_count,
   input wire logic [31:0] cmd_data_addr,
   input wire logic [13:0] cmd_sg_entries,
   output logic [2:0] cmd_slot,
   output logic sel_valid,
   input wire logic sel_ready,
   output logic [2:0] sel_target,
   output logic [7:0] sel_identify,
   output logic sel_tag_en,
   output logic [7:0] sel_tag_msg,
   output logic [7:0] sel_tag_id,
   output logic sel_sync_neg,
   output logic sg_req_valid,
   input wire logic sg_req_ready,
   output logic [31:0] sg_req_addr,
   input wire logic sg_rsp_valid,
   input wire logic [63:0] sg_rsp_data,
   output logic dma_seg_valid,
   output logic [31:0] dma_seg_addr,
   output logic [31:0] dma_seg_len,
   input wire logic scsi_in_valid,
   output logic scsi_in_ready,
   input wire logic [31:0] scsi_in_data,
   output logic host_out_valid,
   input wire logic host_out_ready,
   output logic [31:0] host_out_data,
   input wire logic xfer_done_valid,
   input wire logic [31:0] xfer_moved,
   input wire logic [7:0] xfer_target_status,
   input wire logic recon_valid,
   input wire logic [2:0] recon_target,
   input wire logic recon_tagged,
   input wire logic [2:0] recon_tag,
   input wire logic abort_valid,
   input wire logic [2:0] abort_slot,
   input wire logic bdr_sent,
   input wire logic [2:0] bdr_target,
   input wire logic bus_reset,
   input wire logic bus_reset_self,
   input wire logic ca_valid,
   input wire logic [2:0] ca_target,
   output logic abort_msg_valid,
   output logic [2:0] abort_msg_target,
   output logic sense_req_valid,
   output logic ca_host_valid,
   output logic [2:0] ca_out_target,
   output logic cmpl_valid,
   output logic [2:0] cmpl_slot,
   output logic cmpl_aborted,
   output logic [7:0] cmpl_adapter_status,
   output logic [7:0] cmpl_target_status,
   output logic cmpl_wr_adapter_status,
   output logic cmpl_wr_target_status,
   output logic cmpl_wr_residual,
   output logic [31:0] cmpl_residual,
   output logic cmpl_irq
);
   ccbq_pkg::ccbq_state_t state;
   logic [ccbq_pkg::NSLOT-1:0] slot_valid;
   logic [ccbq_pkg::NSLOT-1:0] slot_tagged;
   logic [ccbq_pkg::NSLOT-1:0] slot_abort;
   logic [2:0] slot_target [ccbq_pkg::NSLOT];
   logic [7:0] slot_ctrl [ccbq_pkg::NSLOT];
   logic [ccbq_pkg::NSLOT-1:0] flush_pend;
   logic [ccbq_pkg::NSLOT-1:0] flush_abt;
   logic [7:0] flush_stat [ccbq_pkg::NSLOT];
   logic [ccbq_pkg::NSLOT-1:0] hit_flush;
   logic [ccbq_pkg::NSLOT-1:0] hit_abort;
   logic [ccbq_pkg::NSLOT-1:0] tag_out_here;
   logic [2:0] free_sel;
   logic free_any;
   logic [2:0] flush_sel;
   logic emit_flush;
   logic alloc;
   logic done_fire;
   logic recon_bad;
   logic abort_now;
   logic [7:0] eff_ctrl;
   logic [7:0] cur_ctrl;
   logic [7:0] cur_opcode;
   logic [2:0] cur_slot;
   logic cur_sg;
   logic [31:0] cur_addr;
   logic [31:0] expect_cnt;
   logic [13:0] sg_total;
   logic [13:0] sg_idx;
   logic [31:0] done_resid;
   logic [7:0] done_astat;
   logic [7:0] done_tstat;
   logic tag_req;
   logic [7:0] reset_stat;

   // Target mode leaves the flags without meaning; reserved bits dropped
   assign eff_ctrl = target_mode ? 8'h00 :
                     (cmd_control & ccbq_pkg::CTRL_USED_MASK);

   always_comb begin
      free_sel = 3'h0;
      free_any = 1'b0;
      flush_sel = 3'h0;
      for (int i = ccbq_pkg::NSLOT - 1; i >= 0; i--) begin
         if (!slot_valid[i] && !flush_pend[i]) begin
            free_sel = 3'(i);
            free_any = 1'b1;
         end
         if (flush_pend[i]) begin
            flush_sel = 3'(i);
         end
      end
   end

   assign cmd_ready = (state == ccbq_pkg::ST_IDLE) & free_any;
   assign alloc = cmd_valid & cmd_ready;
   assign done_fire = (state == ccbq_pkg::ST_DATA) & xfer_done_valid;
   assign recon_bad = recon_valid & !recon_tagged & (|tag_out_here);
   assign abort_now = |hit_abort;
   assign emit_flush = (|flush_pend) & (state != ccbq_pkg::ST_DONE);
   assign reset_stat = bus_reset_self ? ccbq_pkg::STAT_RST_SELF :
                       ccbq_pkg::STAT_RST_OTHER;

   for (genvar s = 0; s < ccbq_pkg::NSLOT; s++) begin : g_slot
      logic hit_rst;
      logic hit_bdr;
      logic hit_recon;
      logic hit_abt_untag;
      logic hit_abt_tag;
      assign tag_out_here[s] = slot_valid[s] & slot_tagged[s] &
                               (slot_target[s] == recon_target);
      assign hit_rst = bus_reset & slot_valid[s];
      assign hit_bdr = bdr_sent & slot_valid[s] &
                       (slot_target[s] == bdr_target);
      assign hit_recon = recon_bad & slot_valid[s] &
                         (slot_target[s] == recon_target);
      assign hit_abt_untag = abort_valid & (abort_slot == 3'(s)) &
                             slot_valid[s] & !slot_tagged[s];
      // Tagged abort only once the target brings back this nexus
      assign hit_abt_tag = recon_valid & recon_tagged &
                           (recon_tag == 3'(s)) & slot_valid[s] &
                           slot_abort[s] &
                           (slot_target[s] == recon_target);
      assign hit_abort[s] = hit_abt_untag | hit_abt_tag;
      assign hit_flush[s] = hit_rst | hit_bdr | hit_recon | hit_abort[s];

      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            slot_valid[s] <= 1'b0;
            slot_tagged[s] <= 1'b0;
            slot_abort[s] <= 1'b0;
            slot_target[s] <= 3'h0;
            slot_ctrl[s] <= 8'h00;
         end else if (hit_flush[s]) begin
            slot_valid[s] <= 1'b0;
            slot_abort[s] <= 1'b0;
         end else if (done_fire && cur_slot == 3'(s)) begin
            slot_valid[s] <= 1'b0;
         end else if (alloc && free_sel == 3'(s)) begin
            slot_valid[s] <= 1'b1;
            slot_tagged[s] <= tag_req;
            slot_abort[s] <= 1'b0;
            slot_target[s] <= cmd_target;
            slot_ctrl[s] <= eff_ctrl;
         end else if (abort_valid && abort_slot == 3'(s) &&
                      slot_valid[s] && slot_tagged[s]) begin
            slot_abort[s] <= 1'b1;
         end
      end

      // A new mark wins over the clear of an emitted entry
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            flush_pend[s] <= 1'b0;
            flush_abt[s] <= 1'b0;
            flush_stat[s] <= 8'h00;
         end else if (hit_flush[s]) begin
            flush_pend[s] <= 1'b1;
            flush_abt[s] <= hit_abort[s] & !hit_rst & !hit_bdr & !hit_recon;
            flush_stat[s] <= hit_rst ? reset_stat :
                             hit_bdr ? ccbq_pkg::STAT_BDR :
                             hit_recon ? ccbq_pkg::STAT_UNTAGGED_RECON :
                             ccbq_pkg::STAT_OK;
         end else if (emit_flush && flush_sel == 3'(s)) begin
            flush_pend[s] <= 1'b0;
         end
      end
   end

   // Negotiation pending means the tag is held back for this command
   assign tag_req = cmd_lun_tag[ccbq_pkg::LUN_TAG_EN] &
                    !sync_needed[cmd_target];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sel_target <= 3'h0;
         sel_identify <= 8'h00;
         sel_tag_en <= 1'b0;
         sel_tag_msg <= 8'h00;
         sel_tag_id <= 8'h00;
         sel_sync_neg <= 1'b0;
         cmd_slot <= 3'h0;
      end else if (alloc) begin
         sel_target <= cmd_target;
         if (eff_ctrl[ccbq_pkg::CTRL_NO_DISC]) begin
            sel_identify <= ccbq_pkg::IDENT_NO_DISC;
         end else if (opt_valid && opt_no_disc[cmd_target]) begin
            sel_identify <= ccbq_pkg::IDENT_NO_DISC;
         end else begin
            sel_identify <= ccbq_pkg::IDENT_DISC | {5'h00, cmd_lun_tag[2:0]};
         end
         sel_tag_en <= tag_req;
         case (cmd_lun_tag[7:ccbq_pkg::LUN_TYPE_LO])
            2'b01: sel_tag_msg <= ccbq_pkg::MSG_TAG_HEAD;
            2'b10: sel_tag_msg <= ccbq_pkg::MSG_TAG_ORDERED;
            default: sel_tag_msg <= ccbq_pkg::MSG_TAG_SIMPLE;
         endcase
         sel_tag_id <= {5'h00, free_sel};
         sel_sync_neg <= sync_needed[cmd_target];
         cmd_slot <= free_sel;
      end
   end

   assign sel_valid = (state == ccbq_pkg::ST_SELECT);
   assign sg_req_valid = (state == ccbq_pkg::ST_SG_REQ);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= ccbq_pkg::ST_IDLE;
      end else if (state != ccbq_pkg::ST_IDLE && state != ccbq_pkg::ST_DONE &&
                   hit_flush[cur_slot]) begin
         state <= ccbq_pkg::ST_IDLE;
      end else begin
         case (state)
            ccbq_pkg::ST_IDLE: begin
               if (alloc) begin
                  state <= ccbq_pkg::ST_SELECT;
               end
            end
            ccbq_pkg::ST_SELECT: begin
               if (sel_ready) begin
                  state <= (cur_sg && sg_total != 14'h0) ?
                           ccbq_pkg::ST_SG_REQ : ccbq_pkg::ST_DATA;
               end
            end
            ccbq_pkg::ST_SG_REQ: begin
               if (sg_req_ready) begin
                  state <= ccbq_pkg::ST_SG_WAIT;
               end
            end
            ccbq_pkg::ST_SG_WAIT: begin
               if (sg_rsp_valid) begin
                  state <= (sg_idx + 14'h1 == sg_total) ?
                           ccbq_pkg::ST_DATA : ccbq_pkg::ST_SG_REQ;
               end
            end
            ccbq_pkg::ST_DATA: begin
               if (xfer_done_valid) begin
                  state <= ccbq_pkg::ST_DONE;
               end
            end
            ccbq_pkg::ST_DONE: state <= ccbq_pkg::ST_IDLE;
            default: state <= ccbq_pkg::ST_IDLE;
         endcase
      end
   end

   // Command context and segment list walk
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cur_ctrl <= 8'h00;
         cur_opcode <= 8'h00;
         cur_slot <= 3'h0;
         cur_sg <= 1'b0;
         cur_addr <= 32'h0000_0000;
         expect_cnt <= 32'h0000_0000;
         sg_total <= 14'h0;
         sg_idx <= 14'h0;
      end else if (alloc) begin
         cur_ctrl <= eff_ctrl;
         cur_opcode <= cmd_opcode;
         cur_slot <= free_sel;
         cur_sg <= cmd_sg;
         cur_addr <= cmd_data_addr;
         expect_cnt <= cmd_sg ? 32'h0000_0000 : cmd_data_count;
         // Over-long lists are cut to the largest legal length
         sg_total <= (cmd_sg_entries > ccbq_pkg::SG_MAX_ENTRIES) ?
                     ccbq_pkg::SG_MAX_ENTRIES : cmd_sg_entries;
         sg_idx <= 14'h0;
      end else if (state == ccbq_pkg::ST_SG_WAIT && sg_rsp_valid) begin
         expect_cnt <= expect_cnt + sg_rsp_data[31:0];
         cur_addr <= cur_addr + ccbq_pkg::SG_ENTRY_BYTES;
         sg_idx <= sg_idx + 14'h1;
      end
   end

   assign sg_req_addr = cur_addr;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dma_seg_valid <= 1'b0;
         dma_seg_addr <= 32'h0000_0000;
         dma_seg_len <= 32'h0000_0000;
      end else begin
         dma_seg_valid <= 1'b0;
         if (state == ccbq_pkg::ST_SG_WAIT && sg_rsp_valid) begin
            dma_seg_valid <= !cur_ctrl[ccbq_pkg::CTRL_NO_DATA];
            dma_seg_addr <= sg_rsp_data[63:32];
            dma_seg_len <= sg_rsp_data[31:0];
         end else if (state == ccbq_pkg::ST_SELECT && sel_ready && !cur_sg) begin
            dma_seg_valid <= !cur_ctrl[ccbq_pkg::CTRL_NO_DATA];
            dma_seg_addr <= cur_addr;
            dma_seg_len <= expect_cnt;
         end
      end
   end

   // With no data the target stream is drained so the bus never hangs
   logic fifo_in_valid;
   logic fifo_in_ready;
   assign fifo_in_valid = scsi_in_valid & (state == ccbq_pkg::ST_DATA) &
                          !cur_ctrl[ccbq_pkg::CTRL_NO_DATA];
   assign scsi_in_ready = (state == ccbq_pkg::ST_DATA) &
                          (cur_ctrl[ccbq_pkg::CTRL_NO_DATA] | fifo_in_ready);

   ccbq_fifo #(
      .WIDTH(ccbq_pkg::DATA_W),
      .DEPTH(ccbq_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(scsi_in_data),
      .out_valid(host_out_valid),
      .out_ready(host_out_ready),
      .out_data(host_out_data)
   );

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         done_resid <= 32'h0000_0000;
         done_astat <= 8'h00;
         done_tstat <= 8'h00;
      end else if (done_fire) begin
         done_resid <= expect_cnt - xfer_moved;
         done_tstat <= xfer_target_status;
         if (xfer_moved != expect_cnt &&
             !cur_ctrl[ccbq_pkg::CTRL_NO_UNDERRUN]) begin
            done_astat <= ccbq_pkg::STAT_UNDERRUN;
         end else begin
            done_astat <= ccbq_pkg::STAT_OK;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cmpl_valid <= 1'b0;
         cmpl_slot <= 3'h0;
         cmpl_aborted <= 1'b0;
         cmpl_adapter_status <= 8'h00;
         cmpl_target_status <= 8'h00;
         cmpl_wr_adapter_status <= 1'b0;
         cmpl_wr_target_status <= 1'b0;
         cmpl_wr_residual <= 1'b0;
         cmpl_residual <= 32'h0000_0000;
         cmpl_irq <= 1'b0;
      end else if (state == ccbq_pkg::ST_DONE) begin
         cmpl_valid <= 1'b1;
         cmpl_slot <= cur_slot;
         cmpl_aborted <= 1'b0;
         cmpl_adapter_status <= done_astat;
         cmpl_target_status <= done_tstat;
         cmpl_wr_adapter_status <= !(cur_ctrl[ccbq_pkg::CTRL_NO_ZERO_STAT] &&
                                     done_astat == 8'h00);
         cmpl_wr_target_status <= !(cur_ctrl[ccbq_pkg::CTRL_NO_ZERO_STAT] &&
                                    done_tstat == 8'h00);
         cmpl_wr_residual <= (cur_opcode == ccbq_pkg::OPC_RESID_A) ||
                             (cur_opcode == ccbq_pkg::OPC_RESID_B);
         cmpl_residual <= done_resid;
         cmpl_irq <= !cur_ctrl[ccbq_pkg::CTRL_NO_INTR];
      end else if (emit_flush) begin
         cmpl_valid <= 1'b1;
         cmpl_slot <= flush_sel;
         cmpl_aborted <= flush_abt[flush_sel];
         cmpl_adapter_status <= flush_stat[flush_sel];
         cmpl_target_status <= 8'h00;
         cmpl_wr_adapter_status <=
            !(slot_ctrl[flush_sel][ccbq_pkg::CTRL_NO_ZERO_STAT] &&
              flush_stat[flush_sel] == 8'h00);
         cmpl_wr_target_status <=
            !slot_ctrl[flush_sel][ccbq_pkg::CTRL_NO_ZERO_STAT];
         cmpl_wr_residual <= 1'b0;
         cmpl_residual <= 32'h0000_0000;
         cmpl_irq <= !slot_ctrl[flush_sel][ccbq_pkg::CTRL_NO_INTR];
      end else begin
         cmpl_valid <= 1'b0;
         cmpl_irq <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         abort_msg_valid <= 1'b0;
         abort_msg_target <= 3'h0;
      end else begin
         abort_msg_valid <= recon_bad | abort_now;
         if (recon_bad || (recon_valid && abort_now)) begin
            abort_msg_target <= recon_target;
         end else if (abort_now) begin
            abort_msg_target <= slot_target[abort_slot];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sense_req_valid <= 1'b0;
         ca_host_valid <= 1'b0;
         ca_out_target <= 3'h0;
      end else begin
         sense_req_valid <= ca_valid & auto_sense_en;
         ca_host_valid <= ca_valid & !auto_sense_en;
         if (ca_valid) begin
            ca_out_target <= ca_target;
         end
      end
   end
endmodule : ccbq_ctrl

// ==== ccbq_ctrl_props.sv ====
`timescale 1ns/1ps
module ccbq_ctrl_props (
   input wire logic clk_sys, rst_b, cmd_valid, cmd_ready, target_mode,
   input wire logic sel_valid, sel_tag_en, sel_sync_neg, cmpl_valid,
   input wire logic cmpl_irq, ca_valid, auto_sense_en, sense_req_valid,
   input wire logic ca_host_valid, sg_rsp_valid, dma_seg_valid,
   input wire logic xfer_done_valid, scsi_in_ready, bus_reset, bdr_sent,
   input wire logic recon_valid, abort_valid,
   input wire logic [7:0] cmd_control, sel_identify, sel_tag_msg,
   input wire logic [63:0] sg_rsp_data,
   input wire logic [31:0] dma_seg_addr, dma_seg_len
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_nodisc; cmd_valid && cmd_ready && cmd_control[3] &&
      !target_mode |=> sel_identify == 8'h80; endproperty
   a_nodisc: assert property (p_nodisc) else $error("identify");
   property p_irq; cmpl_irq |-> cmpl_valid; endproperty
   a_irq: assert property (p_irq) else $error("stray irq");
   property p_done; xfer_done_valid && scsi_in_ready && !(bus_reset ||
      bdr_sent || recon_valid || abort_valid) |-> ##2 cmpl_valid; endproperty
   a_done: assert property (p_done) else $error("no completion");
   property p_sense; ca_valid && auto_sense_en |=> sense_req_valid &&
      !ca_host_valid; endproperty
   a_sense: assert property (p_sense) else $error("sense");
   property p_host; ca_valid && !auto_sense_en |=> ca_host_valid &&
      !sense_req_valid; endproperty
   a_host: assert property (p_host) else $error("host ca");
   property p_sync; sel_valid && sel_sync_neg |-> !sel_tag_en; endproperty
   a_sync: assert property (p_sync) else $error("tag over sync");
   property p_tag; sel_valid && sel_tag_en |->
      sel_tag_msg inside {8'h20, 8'h21, 8'h22}; endproperty
   a_tag: assert property (p_tag) else $error("tag message");
   property p_seg; sg_rsp_valid ##1 dma_seg_valid |->
      {dma_seg_addr, dma_seg_len} == $past(sg_rsp_data); endproperty
   a_seg: assert property (p_seg) else $error("segment");
   c_irq: cover property (cmpl_valid && cmpl_irq);
   c_seg: cover property (dma_seg_valid);
   c_sense: cover property (sense_req_valid);
endmodule : ccbq_ctrl_props
bind ccbq_ctrl ccbq_ctrl_props u_props (.*);

// ==== ccbq_host_model.sv ====
`timescale 1ns/1ps
module ccbq_host_model (
   input wire logic clk_sys, rst_b, slow, sel_valid, sg_req_valid,
   input wire logic [31:0] sg_req_addr,
   output logic sel_ready, sg_req_ready, sg_rsp_valid,
   output logic [63:0] sg_rsp_data
);
   logic [1:0] wait_cnt;
   logic take;
   assign take = sg_req_valid && sg_req_ready;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {wait_cnt, sel_ready, sg_req_ready, sg_rsp_valid, sg_rsp_data} <= '0;
      end else begin
         sel_ready <= 1'b0;
         sg_req_ready <= 1'b0;
         sg_rsp_valid <= take;
         // Count then address, LSB first; idle lines toggle
         sg_rsp_data <= take ? {sg_req_addr + 32'h100, 16'h0,
            sg_req_addr[15:0]} : ~sg_rsp_data;
         if ((sel_valid || sg_req_valid) && !sel_ready && !sg_req_ready) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (!slow || wait_cnt == 2'h3) begin
               sel_ready <= sel_valid;
               sg_req_ready <= sg_req_valid;
            end
         end
      end
   end
endmodule : ccbq_host_model

// ==== ccbq_ctrl_tb.sv ====
`timescale 1ns/1ps
module ccbq_ctrl_tb;
   localparam int LIM = 70000;
   logic clk_sys, rst_b, target_mode, opt_valid, auto_sense_en, cmd_valid;
   logic cmd_ready, cmd_sg, sel_valid, sel_ready, sel_tag_en, sel_sync_neg;
   logic sg_req_valid, sg_req_ready, sg_rsp_valid, dma_seg_valid, slow;
   logic scsi_in_valid, scsi_in_ready, host_out_valid, host_out_ready;
   logic xfer_done_valid, recon_valid, recon_tagged, abort_valid, bdr_sent;
   logic bus_reset, bus_reset_self, ca_valid, abort_msg_valid, cmpl_irq;
   logic sense_req_valid, ca_host_valid, cmpl_valid, cmpl_aborted;
   logic cmpl_wr_adapter_status, cmpl_wr_target_status, cmpl_wr_residual;
   logic [2:0] cmd_target, cmd_slot, sel_target, recon_target, recon_tag;
   logic [2:0] abort_slot, bdr_target, ca_target, abort_msg_target;
   logic [2:0] ca_out_target, cmpl_slot;
   logic [7:0] opt_no_disc, sync_needed, cmd_opcode, cmd_control, cmd_lun_tag;
   logic [7:0] sel_identify, sel_tag_msg, sel_tag_id, xfer_target_status;
   logic [7:0] cmpl_adapter_status, cmpl_target_status;
   logic [13:0] cmd_sg_entries;
   logic [31:0] cmd_data_count, cmd_data_addr, sg_req_addr, dma_seg_addr;
   logic [31:0] dma_seg_len, scsi_in_data, host_out_data, xfer_moved;
   logic [31:0] cmpl_residual, sum;
   logic [63:0] sg_rsp_data;
   int mismatches, total_checks, n, d;
   ccbq_ctrl dut (.*);
   ccbq_host_model u_host (.*);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task tick;
      @(posedge clk_sys);
      #1;
   endtask : tick
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task print_verdict;
      if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task guard;
      if (n >= LIM) begin
         mismatches++;
         $display("ERROR %0t: timeout", $time);
         print_verdict();
      end
   endtask : guard
   task issue(input logic [7:0] opc, ctl, lt, input logic sg,
         input logic [31:0] cnt, input logic [13:0] ent);
      {cmd_opcode, cmd_control, cmd_lun_tag, cmd_sg} = {opc, ctl, lt, sg};
      {cmd_data_count, cmd_sg_entries, cmd_valid} = {cnt, ent, 1'b1};
      for (n = 0; n < LIM && !cmd_ready; n++) tick;
      guard();
      tick;
      cmd_valid = 1'b0;
      for (n = 0; n < LIM && !scsi_in_ready; n++) tick;
      guard();
   endtask : issue
   task complete(input int fill, input logic [31:0] moved);
      scsi_in_valid = 1'b1;
      for (n = 0; n < 40 && scsi_in_ready; n++) begin
         scsi_in_data = n;
         tick;
      end
      scsi_in_valid = 1'b0;
      chk(n, fill);
      host_out_ready = 1'b1;
      d = 0;
      for (n = 0; n < 40; n++) begin
         if (host_out_valid === 1'b1) begin
            chk(host_out_data, d);
            d++;
         end
         tick;
      end
      host_out_ready = 1'b0;
      chk(d, fill == 40 ? 0 : fill);
      {xfer_moved, xfer_done_valid} = {moved, 1'b1};
      tick;
      xfer_done_valid = 1'b0;
      tick;
      chk(cmpl_valid, 1'b1);
   endtask : complete
   initial begin
      {rst_b, target_mode, opt_valid, auto_sense_en, cmd_valid, cmd_sg,
         scsi_in_valid, host_out_ready, xfer_done_valid, recon_valid,
         recon_tagged, abort_valid, bdr_sent, bus_reset, bus_reset_self,
         ca_valid, slow, cmd_target, recon_target, recon_tag, abort_slot,
         bdr_target, ca_target, opt_no_disc, sync_needed, cmd_opcode,
         cmd_control, cmd_lun_tag, xfer_target_status, cmd_sg_entries,
         cmd_data_count, scsi_in_data, xfer_moved} = '0;
      cmd_data_addr = 32'h2000;
      repeat (12) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      tick;
      chk(cmd_ready, 1'b1);
      {opt_valid, opt_no_disc, cmd_target} = {1'b1, 8'h01, 3'h1};
      issue(8'h03, 8'h00, 8'h02, 1'b0, 32'h80, 14'h0);
      chk(sel_identify, 8'hc2);
      complete(32, 32'h7c);
      chk(cmpl_adapter_status, 8'h12);
      chk(cmpl_residual, 32'h4);
      chk({cmpl_wr_residual, cmpl_irq, cmpl_wr_adapter_status}, 3'h7);
      cmd_target = 3'h2;
      issue(8'h01, 8'hff, 8'h00, 1'b0, 32'h80, 14'h0);
      chk(sel_identify, 8'h80);
      complete(40, 32'h10);
      chk(cmpl_adapter_status, 8'h00);
      chk({cmpl_wr_adapter_status, cmpl_wr_target_status}, 2'h0);
      chk({cmpl_irq, cmpl_wr_residual}, 2'h0);
      {target_mode, opt_valid, sync_needed} = {1'b1, 1'b0, 8'h01};
      {cmd_target, xfer_target_status} = {3'h0, 8'h02};
      issue(8'h04, 8'hf8, 8'h61, 1'b0, 32'h40, 14'h0);
      chk(sel_identify, 8'hc1);
      chk({sel_tag_en, sel_sync_neg}, 2'h1);
      complete(32, 32'h44);
      chk({cmpl_adapter_status, cmpl_target_status}, 16'h1202);
      chk({cmpl_irq, cmpl_wr_residual}, 2'h3);
      chk(cmpl_residual, 32'hffff_fffc);
      {target_mode, sync_needed, xfer_target_status, slow} = 18'h1;
      sum = 32'h0;
      for (d = 0; d < 8192; d++) sum += (32'h2000 + 8 * d) & 32'hffff;
      issue(8'h01, 8'h00, 8'ha0, 1'b1, 32'h0, 14'h2000);
      chk({sel_tag_en, sel_tag_msg}, 9'h122);
      chk(dma_seg_addr, 32'h0001_20f8);
      complete(32, sum);
      chk(cmpl_adapter_status, 8'h00);
      slow = 1'b0;
      for (d = 0; d < 3; d++) begin
         {cmd_target, bdr_target, recon_target, ca_target} = {4{3'h5}};
         issue(8'h01, 8'h00, {2'h0, d[1], 5'h0}, 1'b0, 32'h10,
               14'h0);
         {bus_reset, bus_reset_self, bdr_sent} = d[1] ? 3'h0 : d ? 3'h1 : 3'h6;
         {auto_sense_en, ca_valid, recon_valid} = {d[0], 1'b1, d[1]};
         tick;
         {bus_reset, bdr_sent, ca_valid, recon_valid} = 4'h0;
         chk({sense_req_valid, ca_host_valid, ca_out_target},
             d[0] ? 5'h15 : 5'h0d);
         chk({abort_msg_valid, abort_msg_target},
             d[1] ? 4'hd : 4'h0);
         for (n = 0; n < 20 && cmpl_valid !== 1'b1; n++) tick;
         chk({cmpl_valid, cmpl_adapter_status},
             d[1] ? 9'h124 : d ? 9'h125 : 9'h122);
         chk({cmpl_aborted, cmpl_wr_residual, cmpl_target_status},
             10'h0);
      end
      print_verdict();
   end
endmodule : ccbq_ctrl_tb
